// ===== verilog/apc_pkg.sv
// constants, field layout and types of the access-list packet classifier
package apc_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] APC_CMD_OFS = 8'h00;
    localparam logic [7:0] APC_STAT_OFS = 8'h04;
    localparam logic [7:0] APC_PDIS_OFS = 8'h08;
    localparam logic [7:0] APC_BIND_BASE = 8'h40;
    localparam logic [7:0] APC_STG_BASE = 8'h80;
    localparam int APC_ADDR_W = 8;
    localparam int APC_NW = 16;
    localparam int APC_LIST_W = 4;

    // ----------------------------------------------------------------
    // command, status and binding fields
    // ----------------------------------------------------------------
    localparam int APC_CMD_ADD_BIT = 0;
    localparam int APC_CMD_DEL_BIT = 1;
    localparam int APC_CMD_CLR_BIT = 2;
    localparam int APC_CMD_LIST_LSB = 8;
    localparam int APC_ST_BOUND_BIT = 0;
    localparam int APC_ST_FULL_BIT = 1;
    localparam int APC_ST_BAD_BIT = 2;
    localparam int APC_ST_CNT_LSB = 8;
    localparam int APC_BIND_ON_BIT = 0;
    localparam int APC_BIND_LIST_LSB = 8;

    // ----------------------------------------------------------------
    // rule_entry word 0 layout, plus the word 2 vlan field
    // ----------------------------------------------------------------
    localparam int APC_W0_ACT_LSB = 0;
    localparam int APC_W0_MAC_BIT = 2;
    localparam int APC_W0_ANY_BIT = 3;
    localparam int APC_W0_PROTO_LSB = 4;
    localparam int APC_W0_CARE_LSB = 12;
    localparam int APC_W0_FVAL_LSB = 18;
    localparam int APC_W0_SPEN_BIT = 24;
    localparam int APC_W0_DPEN_BIT = 25;
    localparam int APC_W0_TOS_LSB = 26;
    localparam int APC_W0_VLEN_BIT = 28;
    localparam int APC_W0_ETEN_BIT = 29;
    localparam int APC_W2_VLAN_LSB = 16;

    // ----------------------------------------------------------------
    // protocol numbers, vlan range, reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] APC_PROTO_TCP = 8'h06;
    localparam logic [7:0] APC_PROTO_UDP = 8'h11;
    localparam logic [11:0] APC_VLAN_MIN = 12'h002;
    localparam logic [11:0] APC_VLAN_MAX = 12'hFFE;
    localparam logic [31:0] APC_WORD_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        APC_ACT_PERMIT = 2'h0,
        APC_ACT_DENY = 2'h1,
        APC_ACT_SHUT = 2'h3
    } apc_action_t;

    typedef enum logic [1:0] {
        APC_TOS_NONE = 2'h0,
        APC_TOS_DSCP = 2'h1,
        APC_TOS_PREC = 2'h3
    } apc_tos_t;

endpackage

// ===== verilog/apc_classifier.sv
// access-list packet classifier: rule table, first-match search and port shutdown
`timescale 1ns/1ns
`default_nettype none

module apc_classifier
    import apc_pkg::*;
#(
    parameter int N_ENTRIES = 16,
    parameter int N_PORTS = 10
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [APC_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // parsed packet from the datapath
    input wire logic pkt_valid_i,
    input wire logic [3:0] pkt_port_i,
    input wire logic pkt_is_ip_i,
    input wire logic [7:0] pkt_proto_i,
    input wire logic [5:0] pkt_tcp_flags_i,
    input wire logic [15:0] pkt_sport_i,
    input wire logic [15:0] pkt_dport_i,
    input wire logic [31:0] pkt_sip_i,
    input wire logic [31:0] pkt_dip_i,
    input wire logic [5:0] pkt_dscp_i,
    input wire logic [47:0] pkt_smac_i,
    input wire logic [47:0] pkt_dmac_i,
    input wire logic [11:0] pkt_vlan_i,
    input wire logic [15:0] pkt_etype_i,
    // decision to the datapath
    output logic dec_valid_o,
    output logic [3:0] dec_port_o,
    output logic [1:0] dec_action_o,
    output logic [N_PORTS-1:0] port_dis_o
);

    localparam int CNT_W = $clog2(N_ENTRIES + 1);
    localparam int IDX_W = $clog2(N_ENTRIES);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    generate
        if (N_PORTS < 1 || N_PORTS > 16)
        begin : g_bad_ports
            $error("N_PORTS must be 1 to 16");
        end
        if (N_ENTRIES < 2 || N_ENTRIES > 255)
        begin : g_bad_entries
            $error("N_ENTRIES must be 2 to 255");
        end
    endgenerate

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [31:0] stg [APC_NW];
    logic [31:0] ent_mem [N_ENTRIES][APC_NW];
    logic [N_ENTRIES-1:0] ent_vld;
    logic [APC_LIST_W-1:0] ent_list [N_ENTRIES];
    logic [CNT_W-1:0] wr_ptr;
    logic [N_PORTS-1:0] bind_on;
    logic [APC_LIST_W-1:0] bind_list [N_PORTS];
    logic st_bound;
    logic st_full;
    logic st_bad;

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire wr_cmd = reg_wr_i && reg_addr_i == APC_CMD_OFS;
    wire wr_stat = reg_wr_i && reg_addr_i == APC_STAT_OFS;
    wire wr_pdis = reg_wr_i && reg_addr_i == APC_PDIS_OFS;
    wire sel_bind = reg_addr_i[7:6] == APC_BIND_BASE[7:6];
    wire sel_stg = reg_addr_i[7:6] == APC_STG_BASE[7:6];
    wire [3:0] bind_idx = reg_addr_i[5:2];
    wire [3:0] stg_idx = reg_addr_i[5:2];
    wire bind_hit = sel_bind && 32'(bind_idx) < N_PORTS;
    wire [APC_LIST_W-1:0] cmd_list = reg_wdata_i[APC_CMD_LIST_LSB +: APC_LIST_W];
    wire cmd_add = wr_cmd && reg_wdata_i[APC_CMD_ADD_BIT];
    wire cmd_del = wr_cmd && reg_wdata_i[APC_CMD_DEL_BIT];
    wire cmd_clr = wr_cmd && reg_wdata_i[APC_CMD_CLR_BIT];

    // a list is locked against add and delete while any port holds it
    logic list_bound;
    always_comb
    begin
        list_bound = 1'b0;
        for (int p = 0; p < N_PORTS; p++)
        begin
            if (bind_on[p] && bind_list[p] == cmd_list)
            begin
                list_bound = 1'b1;
            end
        end
    end

    // staged entry sanity: vlan range and one kind of tos compare only
    wire [11:0] stg_vlan = stg[2][APC_W2_VLAN_LSB +: 12];
    wire vlan_bad = stg[0][APC_W0_VLEN_BIT] &&
        (stg_vlan < APC_VLAN_MIN || stg_vlan > APC_VLAN_MAX);
    wire [1:0] stg_tos = stg[0][APC_W0_TOS_LSB +: 2];
    wire tos_bad = stg_tos == 2'h2;
    wire tab_full = 32'(wr_ptr) >= N_ENTRIES;
    wire add_ok = cmd_add && !list_bound && !tab_full && !vlan_bad && !tos_bad;
    wire [IDX_W-1:0] add_slot = wr_ptr[IDX_W-1:0];

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [31:0] stat_word = {16'h0000, 8'(wr_ptr), 5'h00, st_bad, st_full, st_bound};
    wire [31:0] bind_word = bind_hit ?
        {16'h0000, 4'h0, bind_list[bind_idx], 7'h00, bind_on[bind_idx]} : 32'h0000_0000;
    wire [31:0] pdis_word = 32'(port_dis_o);
    wire [31:0] rd_mux = (reg_addr_i == APC_STAT_OFS) ? stat_word :
                         (reg_addr_i == APC_PDIS_OFS) ? pdis_word :
                         sel_bind ? bind_word :
                         sel_stg ? stg[stg_idx] : 32'h0000_0000;

    // ----------------------------------------------------------------
    // per-entry match
    // ----------------------------------------------------------------
    wire in_range = 32'(pkt_port_i) < N_PORTS;
    wire pkt_bound = in_range && bind_on[pkt_port_i];
    wire [APC_LIST_W-1:0] pkt_list = in_range ? bind_list[pkt_port_i] : '0;
    wire [N_ENTRIES-1:0] hit;

    genvar gi;
    generate
        for (gi = 0; gi < N_ENTRIES; gi++)
        begin : g_ent
            wire [31:0] w0 = ent_mem[gi][0];
            wire [7:0] proto = w0[APC_W0_PROTO_LSB +: 8];
            wire any = w0[APC_W0_ANY_BIT];
            wire proto_ok = any || pkt_proto_i == proto;
            wire [5:0] care = w0[APC_W0_CARE_LSB +: 6];
            wire [5:0] fval = w0[APC_W0_FVAL_LSB +: 6];
            wire flags_ok = ((pkt_tcp_flags_i ^ fval) & care) == 6'h00;
            wire l4 = !any && (proto == APC_PROTO_TCP || proto == APC_PROTO_UDP);
            wire sp_ok = !(l4 && w0[APC_W0_SPEN_BIT]) ||
                pkt_sport_i == ent_mem[gi][1][15:0];
            wire dp_ok = !(l4 && w0[APC_W0_DPEN_BIT]) ||
                pkt_dport_i == ent_mem[gi][1][31:16];
            wire sip_ok = ((pkt_sip_i ^ ent_mem[gi][4]) & ~ent_mem[gi][5]) ==
                32'h0;
            wire dip_ok = ((pkt_dip_i ^ ent_mem[gi][6]) & ~ent_mem[gi][7]) == 32'h0;
            wire [5:0] tval = ent_mem[gi][2][5:0];
            wire [1:0] tos = w0[APC_W0_TOS_LSB +: 2];
            wire tos_ok = (tos == APC_TOS_DSCP) ? pkt_dscp_i == tval :
                          (tos == APC_TOS_PREC) ? pkt_dscp_i[5:3] == tval[2:0] :
                          1'b1;
            wire ip_hit = pkt_is_ip_i && proto_ok && flags_ok && sp_ok && dp_ok &&
                sip_ok && dip_ok && tos_ok;
            wire [47:0] smac = {ent_mem[gi][9][15:0], ent_mem[gi][8]};
            wire [47:0] smsk = {ent_mem[gi][11][15:0], ent_mem[gi][10]};
            wire [47:0] dmac = {ent_mem[gi][13][15:0], ent_mem[gi][12]};
            wire [47:0] dmsk = {ent_mem[gi][15][15:0], ent_mem[gi][14]};
            wire smac_ok = ((pkt_smac_i ^ smac) & ~smsk) == 48'h0;
            wire dmac_ok = ((pkt_dmac_i ^ dmac) & ~dmsk) == 48'h0;
            wire vlan_ok = !w0[APC_W0_VLEN_BIT] ||
                pkt_vlan_i == ent_mem[gi][2][APC_W2_VLAN_LSB +: 12];
            wire et_ok = !w0[APC_W0_ETEN_BIT] ||
                pkt_etype_i == ent_mem[gi][3][15:0];
            wire mac_hit = smac_ok && dmac_ok && vlan_ok && et_ok;
            assign hit[gi] = ent_vld[gi] && ent_list[gi] == pkt_list &&
                (w0[APC_W0_MAC_BIT] ? mac_hit : ip_hit);
        end
    endgenerate

    // lowest index wins: scan from the top so the last write is the first hit
    logic [1:0] first_act;
    always_comb
    begin
        first_act = APC_ACT_DENY;
        for (int i = N_ENTRIES - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                first_act = ent_mem[i][0][APC_W0_ACT_LSB +: 2];
            end
        end
    end

    wire dec_take = pkt_valid_i && pkt_bound;
    wire shut_now = dec_take && first_act == APC_ACT_SHUT;
    wire [N_PORTS-1:0] shut_vec = shut_now ? N_PORTS'(1) << pkt_port_i : '0;
    wire [N_PORTS-1:0] next_port_dis =
        (port_dis_o & ~(wr_pdis ? reg_wdata_i[N_PORTS-1:0] : '0)) | shut_vec;

    // ----------------------------------------------------------------
    // registers: control state
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr <= '0;
            ent_vld <= '0;
            bind_on <= '0;
            st_bound <= 1'b0;
            st_full <= 1'b0;
            st_bad <= 1'b0;
            for (int p = 0; p < N_PORTS; p++)
            begin
                bind_list[p] <= '0;
            end
            for (int i = 0; i < N_ENTRIES; i++)
            begin
                ent_list[i] <= '0;
            end
        end
        else
        begin
            // a fresh reject wins over a clear in the same cycle
            st_bound <= (st_bound && !(wr_stat && reg_wdata_i[APC_ST_BOUND_BIT])) ||
                (cmd_add && list_bound);
            st_full <= (st_full && !(wr_stat && reg_wdata_i[APC_ST_FULL_BIT])) ||
                (cmd_add && tab_full);
            st_bad <= (st_bad && !(wr_stat && reg_wdata_i[APC_ST_BAD_BIT])) ||
                (cmd_add && (vlan_bad || tos_bad));
            if (reg_wr_i && bind_hit)
            begin
                bind_on[bind_idx] <= reg_wdata_i[APC_BIND_ON_BIT];
                bind_list[bind_idx] <= reg_wdata_i[APC_BIND_LIST_LSB +: APC_LIST_W];
            end
            if (cmd_clr)
            begin
                wr_ptr <= '0;
                ent_vld <= '0;
            end
            else if (add_ok)
            begin
                // slots are only appended, so table order is insertion order
                ent_vld[add_slot] <= 1'b1;
                ent_list[add_slot] <= cmd_list;
                wr_ptr <= wr_ptr + CNT_W'(1);
            end
            else if (cmd_del && !list_bound)
            begin
                // freed slots are not reused until a clear, to keep ordering simple
                for (int i = 0; i < N_ENTRIES; i++)
                begin
                    if (ent_list[i] == cmd_list)
                    begin
                        ent_vld[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // registers: entry payload, no reset needed behind ent_vld
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i)
    begin
        if (reg_wr_i && sel_stg)
        begin
            stg[stg_idx] <= reg_wdata_i;
        end
        if (add_ok && !cmd_clr)
        begin
            for (int k = 0; k < APC_NW; k++)
            begin
                ent_mem[add_slot][k] <= stg[k];
            end
        end
    end

    // ----------------------------------------------------------------
    // registers: outputs
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            reg_rdata_o <= APC_WORD_RST;
            dec_valid_o <= 1'b0;
            dec_port_o <= 4'h0;
            dec_action_o <= APC_ACT_PERMIT;
            port_dis_o <= '0;
        end
        else
        begin
            reg_rdata_o <= reg_rd_i ? rd_mux : APC_WORD_RST;
            dec_valid_o <= dec_take;
            dec_port_o <= pkt_port_i;
            dec_action_o <= first_act;
            port_dis_o <= next_port_dis;
        end
    end

endmodule

`default_nettype wire

// ===== test/apc_dp_model.sv
// behavioural model of the forwarding datapath that presents parsed headers
`timescale 1ns/1ns
`default_nettype none

module apc_dp_model (
    // clock
    input wire logic core_clk_i,
    // parsed header towards the classifier
    output logic pkt_valid_o,
    output logic [3:0] pkt_port_o,
    output logic pkt_is_ip_o,
    output logic [7:0] pkt_proto_o,
    output logic [5:0] pkt_tcp_flags_o,
    output logic [15:0] pkt_sport_o,
    output logic [15:0] pkt_dport_o,
    output logic [31:0] pkt_sip_o,
    output logic [31:0] pkt_dip_o,
    output logic [5:0] pkt_dscp_o,
    output logic [47:0] pkt_smac_o,
    output logic [47:0] pkt_dmac_o,
    output logic [11:0] pkt_vlan_o,
    output logic [15:0] pkt_etype_o
);
    // ----------------------------------------------------------------
    // header fields set by the bench, sent one packet at a time
    // ----------------------------------------------------------------
    typedef struct packed {
        logic is_ip;
        logic [7:0] proto;
        logic [5:0] flags;
        logic [15:0] sport;
        logic [15:0] dport;
        logic [31:0] sip;
        logic [31:0] dip;
        logic [5:0] dscp;
        logic [47:0] smac;
        logic [47:0] dmac;
        logic [11:0] vlan;
        logic [15:0] etype;
    } apc_hdr_t;
    apc_hdr_t f;

    initial
    begin
        f = '0;
        pkt_valid_o = 1'b0;
        pkt_port_o = 4'h0;
        {pkt_is_ip_o, pkt_proto_o, pkt_tcp_flags_o, pkt_sport_o, pkt_dport_o, pkt_sip_o,
            pkt_dip_o, pkt_dscp_o, pkt_smac_o, pkt_dmac_o, pkt_vlan_o, pkt_etype_o} = '0;
    end

    task automatic send(input logic [3:0] port);
        @(posedge core_clk_i);
        pkt_valid_o <= 1'b1;
        pkt_port_o <= port;
        {pkt_is_ip_o, pkt_proto_o, pkt_tcp_flags_o, pkt_sport_o, pkt_dport_o, pkt_sip_o,
            pkt_dip_o, pkt_dscp_o, pkt_smac_o, pkt_dmac_o, pkt_vlan_o, pkt_etype_o} <= f;
        @(posedge core_clk_i);
        // released fields flip so a late sample never matches by luck
        pkt_valid_o <= 1'b0;
        pkt_port_o <= ~port;
        {pkt_is_ip_o, pkt_proto_o, pkt_tcp_flags_o, pkt_sport_o, pkt_dport_o, pkt_sip_o,
            pkt_dip_o, pkt_dscp_o, pkt_smac_o, pkt_dmac_o, pkt_vlan_o, pkt_etype_o} <= ~f;
    endtask
endmodule

`default_nettype wire

// ===== test/apc_classifier_asserts.sv
// port-level checker of the packet classifier
`timescale 1ns/1ns
`default_nettype none

module apc_classifier_chk
    import apc_pkg::*;
#(
    parameter int N_PORTS = 10
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [APC_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // packets and decisions
    input wire logic pkt_valid_i,
    input wire logic [3:0] pkt_port_i,
    input wire logic dec_valid_o,
    input wire logic [3:0] dec_port_o,
    input wire logic [1:0] dec_action_o,
    input wire logic [N_PORTS-1:0] port_dis_o
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_dec_from_pkt: assert property (
        dec_valid_o |-> $past(pkt_valid_i) && dec_port_o == $past(pkt_port_i))
        else $error("decision without its packet");
    a_no_pkt_quiet: assert property (!pkt_valid_i |=> !dec_valid_o)
        else $error("decision with no packet");
    a_unbound_quiet: assert property (
        pkt_valid_i && pkt_port_i >= N_PORTS |=> !dec_valid_o)
        else $error("decision for a port outside the table");
    a_shut_disables: assert property (
        dec_valid_o && dec_action_o == APC_ACT_SHUT |-> port_dis_o[dec_port_o])
        else $error("shutdown left port enabled");
    a_dis_sticky: assert property (
        !(reg_wr_i && reg_addr_i == APC_PDIS_OFS)
        |=> (port_dis_o & $past(port_dis_o)) == $past(port_dis_o))
        else $error("port re-enabled without software");
    a_dis_cause: assert property (
        (port_dis_o & ~$past(port_dis_o)) != '0 |-> dec_valid_o && dec_action_o == APC_ACT_SHUT)
        else $error("port disabled without shutdown");
    a_pdis_read: assert property (
        $past(reg_rd_i) && $past(reg_addr_i) == APC_PDIS_OFS
        |-> reg_rdata_o == 32'($past(port_dis_o)))
        else $error("disabled ports read wrong");
    a_action_known: assert property (dec_valid_o |-> dec_action_o != 2'h2)
        else $error("unknown action code");
endmodule

bind apc_classifier apc_classifier_chk #(.N_PORTS(N_PORTS)) chk_u (.core_clk_i, .sys_rst_i,
    .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pkt_valid_i, .pkt_port_i,
    .dec_valid_o, .dec_port_o, .dec_action_o, .port_dis_o);

`default_nettype wire

// ===== test/apc_classifier_tb_top.sv
// self-checking testbench of the access-list packet classifier
`timescale 1ns/1ns
`default_nettype none

module apc_classifier_tb_top
    import apc_pkg::*;
;
    // ----------------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------------
    logic core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, pkt_valid_i, pkt_is_ip_i, dec_valid_o;
    logic [7:0] reg_addr_i, pkt_proto_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, pkt_sip_i, pkt_dip_i;
    logic [3:0] pkt_port_i, dec_port_o;
    logic [5:0] pkt_tcp_flags_i, pkt_dscp_i;
    logic [15:0] pkt_sport_i, pkt_dport_i, pkt_etype_i;
    logic [47:0] pkt_smac_i, pkt_dmac_i;
    logic [11:0] pkt_vlan_i;
    logic [1:0] dec_action_o;
    logic [9:0] port_dis_o;
    logic [31:0] stg [16];
    int err_total, checked, cyc;

    apc_classifier dut_u (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .pkt_valid_i, .pkt_port_i, .pkt_is_ip_i, .pkt_proto_i,
        .pkt_tcp_flags_i, .pkt_sport_i, .pkt_dport_i, .pkt_sip_i, .pkt_dip_i, .pkt_dscp_i,
        .pkt_smac_i, .pkt_dmac_i, .pkt_vlan_i, .pkt_etype_i, .dec_valid_o, .dec_port_o,
        .dec_action_o, .port_dis_o);
    apc_dp_model dp_u (.core_clk_i, .pkt_valid_o(pkt_valid_i), .pkt_port_o(pkt_port_i),
        .pkt_is_ip_o(pkt_is_ip_i), .pkt_proto_o(pkt_proto_i), .pkt_tcp_flags_o(pkt_tcp_flags_i),
        .pkt_sport_o(pkt_sport_i), .pkt_dport_o(pkt_dport_i), .pkt_sip_o(pkt_sip_i),
        .pkt_dip_o(pkt_dip_i), .pkt_dscp_o(pkt_dscp_i), .pkt_smac_o(pkt_smac_i),
        .pkt_dmac_o(pkt_dmac_i), .pkt_vlan_o(pkt_vlan_i), .pkt_etype_o(pkt_etype_i));

    initial
    begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, s);
            err_total++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(n, e, reg_rdata_o);
    endtask

    // wildcard words default to all ones so unused addresses match anything
    task automatic st_clr;
        for (int k = 0; k < 16; k++)
            stg[k] = (k inside {5, 7, 10, 11, 14, 15}) ? 32'hFFFF_FFFF : 32'h0000_0000;
    endtask

    task automatic add(input logic [3:0] l);
        for (int k = 0; k < 16; k++)
            wr(APC_STG_BASE + 8'(4 * k), stg[k]);
        wr(APC_CMD_OFS, {20'h00000, l, 8'h01});
    endtask

    task automatic pk(input string n, input logic [3:0] p, input logic v, input logic [1:0] a);
        dp_u.send(p);
        #1 chk({n, " valid"}, 32'(v), 32'(dec_valid_o));
        if (v)
        begin
            chk({n, " action"}, 32'(a), 32'(dec_action_o));
            chk({n, " port"}, 32'(p), 32'(dec_port_o));
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_idle;
        rdc("status", APC_STAT_OFS, 32'h0000_0000);
        rdc("pdis", APC_PDIS_OFS, 32'h0000_0000);
        rdc("bind0", APC_BIND_BASE, 32'h0000_0000);
        rdc("unmapped", 8'h3C, 32'h0000_0000);
        dp_u.f = '0;
        dp_u.f.is_ip = 1'b1;
        dp_u.f.proto = APC_PROTO_TCP;
        dp_u.f.flags = 6'h02;
        dp_u.f.dport = 16'h0050;
        dp_u.f.sip = 32'h0A00_0001;
        dp_u.f.dscp = 6'h2E;
        dp_u.f.smac = 48'h0000_0000_0001;
        dp_u.f.vlan = 12'h064;
        dp_u.f.etype = 16'h0800;
        pk("unbound", 4'h0, 1'b0, APC_ACT_PERMIT);
        pk("outside", 4'hC, 1'b0, APC_ACT_PERMIT);
    endtask

    task automatic t_ip;
        st_clr;
        stg[0] = 32'h0000_0009;
        stg[6] = 32'hAC10_0000;
        stg[7] = 32'h0000_00FF;
        add(4'h1);
        st_clr;
        stg[0] = 32'h0000_0008;
        add(4'h1);
        wr(APC_BIND_BASE + 8'h04, 32'h0000_0101);
        rdc("bind1", APC_BIND_BASE + 8'h04, 32'h0000_0101);
        dp_u.f.dip = 32'hAC10_004D;
        pk("in net", 4'h1, 1'b1, APC_ACT_DENY);
        dp_u.f.dip = 32'hAC10_0105;
        pk("out net", 4'h1, 1'b1, APC_ACT_PERMIT);
        add(4'h1);
        rdc("bound add", APC_STAT_OFS, 32'h0000_0201);
        wr(APC_STAT_OFS, 32'h0000_0007);
        rdc("cleared", APC_STAT_OFS, 32'h0000_0200);
    endtask

    task automatic t_mac;
        st_clr;
        stg[0] = 32'h3000_0007;
        stg[2] = 32'h0064_0000;
        stg[3] = 32'h0000_0800;
        stg[8] = 32'h0857_E01E;
        stg[9] = 32'h0000_0011;
        stg[10] = 32'h0000_0000;
        stg[11] = 32'h0000_0000;
        add(4'h2);
        st_clr;
        stg[0] = 32'h0609_2060;
        stg[1] = 32'h0050_0000;
        stg[2] = 32'h0000_002E;
        stg[4] = 32'h0A00_0000;
        stg[5] = 32'h0000_00FF;
        add(4'h2);
        wr(APC_BIND_BASE + 8'h08, 32'h0000_0201);
        pk("tcp syn", 4'h2, 1'b1, APC_ACT_PERMIT);
        dp_u.f.flags = 6'h12;
        pk("ack set", 4'h2, 1'b1, APC_ACT_DENY);
        dp_u.f.flags = 6'h02;
        dp_u.f.dport = 16'h0051;
        pk("dport", 4'h2, 1'b1, APC_ACT_DENY);
        dp_u.f.dport = 16'h0050;
        dp_u.f.dscp = 6'h2D;
        pk("dscp", 4'h2, 1'b1, APC_ACT_DENY);
        dp_u.f.dscp = 6'h2E;
        dp_u.f.proto = APC_PROTO_UDP;
        pk("proto", 4'h2, 1'b1, APC_ACT_DENY);
        dp_u.f.proto = APC_PROTO_TCP;
        dp_u.f.sip = 32'h0B00_0001;
        pk("sip", 4'h2, 1'b1, APC_ACT_DENY);
        dp_u.f.smac = 48'h0011_0857_E01E;
        dp_u.f.is_ip = 1'b0;
        pk("mac shut", 4'h2, 1'b1, APC_ACT_SHUT);
        chk("dis bit", 32'h0000_0004, 32'(port_dis_o));
        dp_u.f.vlan = 12'h065;
        pk("vlan", 4'h2, 1'b1, APC_ACT_DENY);
        dp_u.f.vlan = 12'h064;
        dp_u.f.etype = 16'h86DD;
        pk("etype", 4'h2, 1'b1, APC_ACT_DENY);
        rdc("pdis set", APC_PDIS_OFS, 32'h0000_0004);
        wr(APC_PDIS_OFS, 32'h0000_0004);
        rdc("pdis clr", APC_PDIS_OFS, 32'h0000_0000);
        st_clr;
        stg[0] = 32'h1000_0000;
        stg[2] = 32'h0FFF_0000;
        add(4'h3);
        rdc("vlan range", APC_STAT_OFS, 32'h0000_0404);
    endtask

    task automatic t_more;
        st_clr;
        stg[0] = 32'h0D00_0111;
        stg[1] = 32'h0000_1234;
        stg[2] = 32'h0000_0005;
        add(4'h4);
        st_clr;
        stg[0] = 32'h0000_0004;
        stg[12] = 32'h4F1D_9FDE;
        stg[13] = 32'h0000_0030;
        stg[14] = 32'h0000_0000;
        stg[15] = 32'h0000_0000;
        add(4'h4);
        wr(APC_BIND_BASE + 8'h0C, 32'h0000_0401);
        dp_u.f.is_ip = 1'b1;
        dp_u.f.proto = APC_PROTO_UDP;
        dp_u.f.sport = 16'h1234;
        dp_u.f.dscp = 6'h2F;
        dp_u.f.dmac = 48'h0030_4F1D_9FDE;
        pk("prec", 4'h3, 1'b1, APC_ACT_DENY);
        dp_u.f.dscp = 6'h26;
        pk("prec miss", 4'h3, 1'b1, APC_ACT_PERMIT);
        dp_u.f.dmac = 48'h0030_4F1D_9FDF;
        pk("dmac", 4'h3, 1'b1, APC_ACT_DENY);
        dp_u.f.dmac = 48'h0030_4F1D_9FDE;
        dp_u.f.dscp = 6'h2F;
        dp_u.f.sport = 16'h1235;
        pk("sport", 4'h3, 1'b1, APC_ACT_PERMIT);
        wr(APC_BIND_BASE + 8'h0C, 32'h0000_0000);
        wr(APC_CMD_OFS, 32'h0000_0402);
        wr(APC_BIND_BASE + 8'h0C, 32'h0000_0401);
        pk("deleted", 4'h3, 1'b1, APC_ACT_DENY);
        rdc("del count", APC_STAT_OFS, 32'h0000_0604);
        wr(APC_CMD_OFS, 32'h0000_0004);
        st_clr;
        for (int i = 0; i < 17; i++)
            add(4'h5);
        rdc("full", APC_STAT_OFS, 32'h0000_1006);
    endtask

    // ----------------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------------
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            err_total++;
            end_sim;
        end
    end

    initial
    begin
        sys_rst_i = 1'b1;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0000_0000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        err_total = 0;
        checked = 0;
        cyc = 0;
        repeat (20) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        t_idle;
        t_ip;
        t_mac;
        t_more;
        end_sim;
    end
endmodule

`default_nettype wire
